// ---- include/rpc_pkg.sv ----
// Constants, types and register map of the reset and power-on control block
package rpc_pkg;

    // ------------------------------------------------------------
    // Behaviour
    // ------------------------------------------------------------
    // Behaviour
    // - Entering reset halts the processor core.
    // - Entering reset loads every special function register with its default.
    // - Entering reset disables all interrupts and timers.
    // - Reset leaves data RAM untouched while power stays.
    // - Stack pointer returns to default; stack data become unreachable.
    // - Port latches go to all ones, open drain, weak pull-ups on.
    // - Supply-monitor and power-on resets drive the reset pin low until exit.
    // - On exit program counter clears and clock selects the internal oscillator.
    // - On exit the watchdog runs from system clock divided by twelve.
    // - After any reset fetch starts at address zero.
    // - Power-up holds reset, plus a release delay above the threshold.
    // - Release delay about 7 ms at 1.8 V, 15 ms at 3.6 V; here one fixed POR_DELAY_CYC at any supply, default 7 ms.
    // - Power-on exit sets the power-on flag, bit 1 of cause register.
    // - Other resets clear the power-on flag; other flags then undefined.
    // - The power-on monitor watches the supply even in sleep.
    // - Writing one to mode bit 5 turns the power-on monitor off.
    // - With monitor off any reset becomes full power-on, re-enabling it.
    // - Power-fail reset sets the power-on flag and enables the supply monitor.

    // ------------------------------------------------------------
    // Register map (word addresses)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CAUSE      = 4'h0;
    localparam logic [3:0]  ADDR_PMODE      = 4'h1;
    localparam logic [3:0]  ADDR_STATUS     = 4'h2;
    localparam logic [3:0]  ADDR_SWRST      = 4'h3;
    localparam int          CAUSE_POR_BIT   = 1;
    localparam int          CAUSE_PIN_BIT   = 0;
    localparam int          CAUSE_SUP_BIT   = 2;
    localparam int          CAUSE_SW_BIT    = 4;
    localparam int          CAUSE_WDT_BIT   = 3;
    localparam int          PMODE_POR_MONITOR_DISABLE_BIT = 5;
    localparam logic [7:0]  PORT_RESET      = 8'hFF;
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam logic [7:0]  SP_RESET        = 8'h07;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          POR_DELAY_LO_MS = 7;
    localparam int          POR_DELAY_HI_MS = 15;
    localparam int          POR_DELAY_LO_CYC = POR_DELAY_LO_MS * (CLK_HZ / 1000);
    localparam int          POR_DELAY_HI_CYC = POR_DELAY_HI_MS * (CLK_HZ / 1000);
    localparam int          WDT_DIV         = 12;
    localparam int          RST_SYNC_LEN    = 2;

    typedef enum logic [1:0] {
        ST_POR_HOLD  = 2'b00,
        ST_POR_DELAY = 2'b01,
        ST_RUN       = 2'b10,
        ST_RESET     = 2'b11
    } rpc_state_t;

endpackage

// ---- include/rpc_rst_if.sv ----
// Interface carrying the raw reset request to the release synchroniser
`timescale 1ns/1ps
interface rpc_rst_if;
    logic req;
    logic sync_rst;
    modport src (output req, input sync_rst);
    modport dst (input req, output sync_rst);
endinterface

// ---- core/rpc_rst_sync.sv ----
// Reset synchroniser: asynchronous assertion, synchronous release
`timescale 1ns/1ps
module rpc_rst_sync (
    input  wire logic clk,
    rpc_rst_if.dst    rif
);
    logic [rpc_pkg::RST_SYNC_LEN-1:0] chain_q;

    always_ff @(posedge clk or posedge rif.req) begin
        if (rif.req) begin
            chain_q <= '1;
        end else begin
            chain_q <= {chain_q[rpc_pkg::RST_SYNC_LEN-2:0], 1'b0};
        end
    end

    assign rif.sync_rst = chain_q[rpc_pkg::RST_SYNC_LEN-1];
endmodule

// ---- core/rpc_reset_ctrl.sv ----
// Reset and power-on control top level with Avalon-MM register slave
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rpc_reset_ctrl #(
    parameter int POR_DELAY_CYC = rpc_pkg::POR_DELAY_LO_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        por_ok,
    input  wire logic        supply_ok,
    input  wire logic        supply_mon_en,
    input  wire logic        pin_rst_in,
    input  wire logic        wdt_expired,
    input  wire logic        sleep_mode,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             core_halt,
    output logic             sfr_reset,
    output logic             irq_timer_disable,
    output logic [15:0]      pc_value,
    output logic [7:0]       sp_value,
    output logic [7:0]       port_latch,
    output logic             port_open_drain,
    output logic             weak_pullup_en,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    output logic             clk_sel_internal,
    output logic             wdt_enable,
    output logic             wdt_tick,
    output logic             por_monitor_on,
    output logic             supply_mon_reset_en
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
        end else begin
            s1_q <= {por_ok, supply_ok, pin_rst_in, wdt_expired, sleep_mode};
            s2_q <= s1_q;
        end
    end
    logic por_ok_s, sup_ok_s, pin_s, wdt_s, sleep_s;
    assign {por_ok_s, sup_ok_s, pin_s, wdt_s, sleep_s} = s2_q;

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    rpc_pkg::rpc_state_t state_q;
    logic [31:0]         cnt_q;
    logic                por_monitor_disable_q;
    logic                supmon_sel_q;
    logic [7:0]          cause_q;
    logic                sw_req_q;
    logic                is_por_q;
    logic                ack_q;

    // Monitor stays active in sleep; only the disable bit turns it off
    logic por_mon_active;
    assign por_mon_active = !por_monitor_disable_q;
    logic por_fail;
    assign por_fail = por_mon_active && !por_ok_s;
    logic sup_fail;
    assign sup_fail = supmon_sel_q && supply_mon_en && !sup_ok_s && !sleep_s;
    logic other_src;
    assign other_src = pin_s || wdt_s || sw_req_q || sup_fail;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= rpc_pkg::ST_POR_HOLD;
            cnt_q   <= 32'h0000_0000;
            is_por_q <= 1'b1;
        end else begin
            case (state_q)
                rpc_pkg::ST_POR_HOLD: begin
                    cnt_q <= 32'h0000_0000;
                    if (por_ok_s) begin
                        state_q <= rpc_pkg::ST_POR_DELAY;
                    end
                end
                rpc_pkg::ST_POR_DELAY: begin
                    if (!por_ok_s) begin
                        state_q <= rpc_pkg::ST_POR_HOLD;
                    end else if (cnt_q == 32'(POR_DELAY_CYC - 1)) begin
                        state_q <= rpc_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                rpc_pkg::ST_RUN: begin
                    if (por_fail || (por_monitor_disable_q && other_src)) begin
                        state_q  <= rpc_pkg::ST_POR_HOLD;
                        is_por_q <= 1'b1;
                    end else if (other_src) begin
                        state_q  <= rpc_pkg::ST_RESET;
                        is_por_q <= sup_fail;
                    end
                end
                rpc_pkg::ST_RESET: begin
                    if (por_fail) begin
                        state_q  <= rpc_pkg::ST_POR_HOLD;
                        is_por_q <= 1'b1;
                    end else if (!pin_s && !wdt_s && !sw_req_q && !sup_fail) begin
                        state_q <= rpc_pkg::ST_RUN;
                    end
                end
                default: state_q <= rpc_pkg::ST_POR_HOLD;
            endcase
        end
    end

    logic in_reset;
    assign in_reset = (state_q != rpc_pkg::ST_RUN);

    // ------------------------------------------------------------
    // Synchronous release of the internal reset
    // ------------------------------------------------------------
    rpc_rst_if rif ();
    assign rif.req = rst || in_reset;
    rpc_rst_sync u_sync (
        .clk (clk),
        .rif (rif)
    );
    logic core_rst;
    assign core_rst = rif.sync_rst;

    // ------------------------------------------------------------
    // Reset cause and mode registers
    // ------------------------------------------------------------
    logic wr_cause, wr_pmode, wr_swrst;
    // Writes land at the edge where the master sees waitrequest low
    assign wr_cause = avs_write && ack_q && avs_address == rpc_pkg::ADDR_CAUSE;
    assign wr_pmode = avs_write && ack_q && avs_address == rpc_pkg::ADDR_PMODE;
    assign wr_swrst = avs_write && ack_q && avs_address == rpc_pkg::ADDR_SWRST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_monitor_disable_q     <= 1'b0;
            supmon_sel_q <= 1'b1;
            cause_q      <= 8'h02;
        end else if (in_reset) begin
            if (is_por_q) begin
                por_monitor_disable_q     <= 1'b0;
                supmon_sel_q <= 1'b1;
                cause_q      <= 8'h02;
            end else begin
                // Collect every source seen while the reset lasts
                cause_q <= cause_q | {3'b000, sw_req_q, wdt_s, sup_fail, 1'b0, pin_s};
            end
        end else if (other_src) begin
            // Entry into reset starts a fresh record with the power-on flag clear
            cause_q <= {3'b000, sw_req_q, wdt_s, sup_fail, 1'b0, pin_s};
        end else begin
            if (wr_pmode) begin
                por_monitor_disable_q <= avs_writedata[rpc_pkg::PMODE_POR_MONITOR_DISABLE_BIT];
            end
            if (wr_cause) begin
                supmon_sel_q <= avs_writedata[rpc_pkg::CAUSE_POR_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_req_q <= 1'b0;
        end else if (wr_swrst && !in_reset) begin
            sw_req_q <= avs_writedata[0];
        end else if (in_reset && state_q == rpc_pkg::ST_RESET) begin
            sw_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state, then answer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            ack_q           <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
            if (avs_read && !ack_q) begin
                case (avs_address)
                    rpc_pkg::ADDR_CAUSE:  avs_readdata <= {24'h00_0000, cause_q};
                    rpc_pkg::ADDR_PMODE:  avs_readdata <= {26'h000_0000, por_monitor_disable_q, 5'h00};
                    rpc_pkg::ADDR_STATUS: avs_readdata <= {29'h0000_0000, state_q, supmon_sel_q};
                    rpc_pkg::ADDR_SWRST:  avs_readdata <= 32'h0000_0000;
                    default:              avs_readdata <= rpc_pkg::UNMAPPED_DATA;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Reset effects on the core, ports and clocking
    // ------------------------------------------------------------
    logic [3:0] wdt_div_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_halt         <= 1'b1;
            sfr_reset         <= 1'b1;
            irq_timer_disable <= 1'b1;
            pc_value          <= rpc_pkg::PC_RESET;
            sp_value          <= rpc_pkg::SP_RESET;
            port_latch        <= rpc_pkg::PORT_RESET;
            port_open_drain   <= 1'b1;
            weak_pullup_en    <= 1'b1;
            rst_pin_out       <= 1'b0;
            rst_pin_oe        <= 1'b0;
            clk_sel_internal  <= 1'b1;
            wdt_enable        <= 1'b0;
        end else begin
            core_halt         <= core_rst;
            sfr_reset         <= core_rst;
            irq_timer_disable <= core_rst;
            sp_value          <= rpc_pkg::SP_RESET;
            pc_value          <= rpc_pkg::PC_RESET;
            port_latch        <= rpc_pkg::PORT_RESET;
            port_open_drain   <= 1'b1;
            weak_pullup_en    <= 1'b1;
            rst_pin_out       <= 1'b0;
            rst_pin_oe        <= !(core_rst && (is_por_q || sup_fail));
            clk_sel_internal  <= 1'b1;
            wdt_enable        <= !core_rst;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_div_q <= 4'h0;
            wdt_tick  <= 1'b0;
        end else if (core_rst || wdt_div_q == 4'(rpc_pkg::WDT_DIV - 1)) begin
            wdt_div_q <= 4'h0;
            wdt_tick  <= !core_rst;
        end else begin
            wdt_div_q <= wdt_div_q + 4'h1;
            wdt_tick  <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_monitor_on      <= 1'b1;
            supply_mon_reset_en <= 1'b1;
        end else begin
            por_monitor_on      <= por_mon_active;
            supply_mon_reset_en <= supmon_sel_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_rise_above;
        $rose(por_ok_s) && state_q == rpc_pkg::ST_POR_HOLD;
    endsequence
    AST_POR_DELAY: assert property (@(posedge clk) disable iff (rst)
        s_rise_above |=> state_q == rpc_pkg::ST_POR_DELAY)
        else $error("power-on delay not entered");
    AST_HALT: assert property (@(posedge clk) disable iff (rst)
        core_rst |=> core_halt && irq_timer_disable)
        else $error("core not halted in reset");
    AST_PIN: assert property (@(posedge clk) disable iff (rst)
        (core_rst && is_por_q) |=> !rst_pin_oe)
        else $error("reset pin not driven");
    AST_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_q == rpc_pkg::ST_POR_HOLD) |=> cause_q[rpc_pkg::CAUSE_POR_BIT])
        else $error("power-on flag not set");
    AST_CLR: assert property (@(posedge clk) disable iff (rst)
        (state_q == rpc_pkg::ST_RESET && !is_por_q) |=> !cause_q[rpc_pkg::CAUSE_POR_BIT])
        else $error("power-on flag not cleared");
    AST_MON: assert property (@(posedge clk) disable iff (rst)
        (!por_monitor_disable_q && $fell(por_ok_s) && state_q == rpc_pkg::ST_RUN)
            |=> state_q == rpc_pkg::ST_POR_HOLD)
        else $error("monitor did not reset");
    AST_FULL: assert property (@(posedge clk) disable iff (rst)
        (state_q == rpc_pkg::ST_RUN && por_monitor_disable_q && other_src) |=> is_por_q ##1 !por_monitor_disable_q)
        else $error("no full power-on reset");
    AST_WDT: assert property (@(posedge clk) disable iff (rst)
        $rose(wdt_tick) |=> !wdt_tick [*8])
        else $error("watchdog divider wrong");
endmodule

// ---- sim/rpc_supply_model.sv ----
// Supply rail and reset pin model facing the reset controller
`timescale 1ns/1ps
module rpc_supply_model #(
    parameter logic [11:0] POR_MV = 12'h5DC,
    parameter logic [11:0] RST_MV = 12'h6A4
) (
    input  wire logic        clk,
    input  wire logic [11:0] target_mv,
    input  wire logic        rst_pin_out,
    input  wire logic        rst_pin_oe,
    output logic             por_ok,
    output logic             supply_ok,
    output logic             rst_pin_level
);
    logic [11:0] vdd_q = 12'h000;

    // Rail rises in fast steps, well inside the valid ramp time, and drops at once
    always_ff @(posedge clk) begin
        if (vdd_q + 12'h064 < target_mv) vdd_q <= vdd_q + 12'h064;
        else vdd_q <= target_mv;
    end
    assign por_ok    = vdd_q > POR_MV;
    assign supply_ok = vdd_q > RST_MV;
    // Open-drain pin with weak pull-up: low only while the device drives it
    assign rst_pin_level = rst_pin_oe ? 1'b1 : rst_pin_out;
endmodule

// ---- sim/rpc_reset_ctrl_tb_top.sv ----
// Self-checking bench of the reset and power-on controller
`timescale 1ns/1ps
module rpc_reset_ctrl_tb_top;
    localparam int POR_CYC = 20;
    logic        clk, rst, supply_mon_en, pin_rst_in, wdt_expired, sleep_mode;
    logic        avs_read, avs_write, avs_waitrequest, por_ok, supply_ok, rst_pin_level;
    logic        core_halt, sfr_reset, irq_timer_disable, port_open_drain, weak_pullup_en;
    logic        rst_pin_out, rst_pin_oe, clk_sel_internal, wdt_enable, wdt_tick;
    logic        por_monitor_on, supply_mon_reset_en;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] pc_value;
    logic [7:0]  sp_value, port_latch;
    logic [11:0] target_mv;
    int          n_mismatch, compares, i, n, k, src, r;

    rpc_reset_ctrl #(.POR_DELAY_CYC(POR_CYC)) u_rpc_reset_ctrl (.clk(clk), .rst(rst),
        .por_ok(por_ok), .supply_ok(supply_ok), .supply_mon_en(supply_mon_en),
        .pin_rst_in(pin_rst_in), .wdt_expired(wdt_expired), .sleep_mode(sleep_mode),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_halt(core_halt), .sfr_reset(sfr_reset),
        .irq_timer_disable(irq_timer_disable), .pc_value(pc_value), .sp_value(sp_value),
        .port_latch(port_latch), .port_open_drain(port_open_drain),
        .weak_pullup_en(weak_pullup_en), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .clk_sel_internal(clk_sel_internal), .wdt_enable(wdt_enable), .wdt_tick(wdt_tick),
        .por_monitor_on(por_monitor_on), .supply_mon_reset_en(supply_mon_reset_en));
    rpc_supply_model u_rpc_supply_model (.clk(clk), .target_mv(target_mv),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .por_ok(por_ok),
        .supply_ok(supply_ok), .rst_pin_level(rst_pin_level));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_halt(input logic want);
        int j;
        for (j = 0; j < 3000; j++) begin
            @(posedge clk);
            if (core_halt === want) break;
        end
        if (j == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int j;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        for (j = 0; j < 50; j++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (j == 50) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic check_exit;
        chk(32'(pc_value), 32'h0000_0000);
        chk(32'(sp_value), 32'h0000_0007);
        chk(32'({port_latch, port_open_drain, weak_pullup_en}), 32'h0000_03FF);
        chk(32'({clk_sel_internal, wdt_enable}), 32'h0000_0003);
        chk(32'({sfr_reset, irq_timer_disable, rst_pin_level}), 32'h0000_0001);
    endtask
    function automatic logic [31:0] exp_cause(input int s);
        case (s)
            0:       return 32'h0000_0001 << rpc_pkg::CAUSE_PIN_BIT;
            1:       return 32'h0000_0001 << rpc_pkg::CAUSE_WDT_BIT;
            2:       return 32'h0000_0001 << rpc_pkg::CAUSE_SW_BIT;
            default: return 32'h0000_0001 << rpc_pkg::CAUSE_POR_BIT;
        endcase
    endfunction
    task automatic check_por;
        bus(1'b0, rpc_pkg::ADDR_CAUSE, 32'h0000_0000);
        chk(q & exp_cause(3), exp_cause(3));
        chk(32'({por_monitor_on, supply_mon_reset_en}), 32'h0000_0003);
        check_exit();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0; rst = 1'b1; target_mv = 12'h000; supply_mon_en = 1'b1;
        pin_rst_in = 1'b0; wdt_expired = 1'b0; sleep_mode = 1'b0; avs_read = 1'b0;
        avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0000_0000;
        n_mismatch = 0; compares = 0;
        r = $urandom(29465);
        @(negedge clk);
        chk(32'({core_halt, rst_pin_oe}), 32'h0000_0002);
        cyc(8);
        rst <= 1'b0;
        cyc(6);
        chk(32'(core_halt), 32'h0000_0001);
        target_mv <= 12'h708;
        n = 0;
        for (i = 0; i < 3000 && core_halt !== 1'b0; i++) begin
            @(posedge clk);
            if (por_ok === 1'b1) n++;
        end
        if (i == 3000) begin
            n_mismatch++;
            end_of_test();
        end
        chk(32'(n >= POR_CYC), 32'h0000_0001);
        check_por();
        $display("power-up test done");
        for (i = 0; i < 30 && wdt_tick !== 1'b1; i++) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wdt_tick !== 1'b1 && n < 30);
        chk(32'(n), 32'(rpc_pkg::WDT_DIV));
        bus(1'b0, 4'(4 + $urandom % 12), 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("watchdog clock and unmapped read test done");
        r = $urandom % 3;
        for (k = 0; k < 3; k++) begin
            src = (k + r) % 3;
            case (src)
                0:       pin_rst_in <= 1'b1;
                1:       wdt_expired <= 1'b1;
                default: bus(1'b1, rpc_pkg::ADDR_SWRST, 32'h0000_0001);
            endcase
            wait_halt(1'b1);
            cyc(2);
            chk(32'({sfr_reset, irq_timer_disable, rst_pin_level}), 32'h0000_0007);
            cyc(1 + $urandom % 4);
            pin_rst_in <= 1'b0;
            wdt_expired <= 1'b0;
            wait_halt(1'b0);
            check_exit();
            bus(1'b0, rpc_pkg::ADDR_CAUSE, 32'h0000_0000);
            chk(q & (exp_cause(src) | exp_cause(3)), exp_cause(src));
            $display("reset source %0d test done", src);
        end
        target_mv <= 12'h640;
        wait_halt(1'b1);
        cyc(2);
        chk(32'(rst_pin_level), 32'h0000_0000);
        target_mv <= 12'h708;
        wait_halt(1'b0);
        check_por();
        $display("supply fail test done");
        bus(1'b1, rpc_pkg::ADDR_PMODE, ($urandom & 32'h0000_00DF) | 32'h0000_0020);
        cyc(3);
        chk(32'(por_monitor_on), 32'h0000_0000);
        pin_rst_in <= 1'b1;
        wait_halt(1'b1);
        cyc(3);
        pin_rst_in <= 1'b0;
        wait_halt(1'b0);
        check_por();
        $display("monitor disable test done");
        sleep_mode <= 1'b1;
        target_mv <= 12'h3E8;
        wait_halt(1'b1);
        cyc(2);
        chk(32'(rst_pin_level), 32'h0000_0000);
        sleep_mode <= 1'b0;
        target_mv <= 12'h708;
        wait_halt(1'b0);
        check_por();
        $display("sleep supply loss test done");
        @(posedge clk);
        rst <= 1'b1;
        #1 chk(32'(core_halt), 32'h0000_0001);
        @(posedge clk);
        rst <= 1'b0;
        wait_halt(1'b0);
        check_por();
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
